//--- rtl/addr_map_pkg.sv
// Region types for the address space decoder
package addr_map_pkg;
	typedef enum logic [1:0] {
		RF_RAM,
		RF_HOLE,
		RF_CTRL
	} rf_region_t;
	typedef enum logic [2:0] {
		PM_OPTION,
		PM_VECTOR,
		PM_RESERVED,
		PM_CODE,
		PM_INFO,
		PM_UNPOP
	} pm_region_t;
endpackage

//--- rtl/addr_map_regs.svh
// Address map constants for register file and program memory decoding
`ifndef ADDR_MAP_REGS_SVH
`define ADDR_MAP_REGS_SVH
`define RF_SIZE 4096
`define RF_CTRL_BASE 12'hF00
`define RF_CTRL_LAST 12'hFFF
`define RF_RAM_BASE 12'h000
`define RAM_BYTES_DEFAULT 1024
`define RAM_BYTES_MIN 256
`define RAM_BYTES_MAX 1024
`define FLASH_BYTES_DEFAULT 8192
`define FLASH_BYTES_MIN 1024
`define FLASH_BYTES_MAX 8192
`define PM_OPTION_BASE 16'h0000
`define PM_OPTION_LAST 16'h0001
`define PM_RESET_VEC 16'h0002
`define PM_WDOG_VEC 16'h0004
`define PM_ILLEGAL_VEC 16'h0006
`define PM_IRQ_VEC_BASE 16'h0008
`define PM_IRQ_VEC_LAST 16'h0037
`define PM_RSVD_BASE 16'h0038
`define PM_RSVD_LAST 16'h0039
`define PM_OSC_VEC_BASE 16'h003A
`define PM_OSC_VEC_LAST 16'h003D
`define PM_CODE_BASE 16'h003E
`define PM_INFO_BASE 16'hFE00
`define PM_INFO_LAST 16'hFF7F
`define INFO_BYTES 128
`define UNDEF_BYTE 8'h00
`endif

//--- rtl/addr_space_decoder.sv
// Register file and program memory address decoder for the core
`timescale 1ns/1ps
`include "addr_map_regs.svh"
module addr_space_decoder #(
	parameter int RAM_BYTES = `RAM_BYTES_DEFAULT,
	parameter int FLASH_BYTES = `FLASH_BYTES_DEFAULT
) (
	input wire logic sys_clk_in, // Core clock, 20 MHz
	input wire logic reset_in, // Synchronous reset, active high
	// Register file port
	input wire logic rf_rd_in, // Register read strobe
	input wire logic rf_wr_in, // Register write strobe
	input wire logic [11:0] rf_addr_in, // Register file address
	input wire logic [7:0] rf_wdata_in, // Register write data
	output logic [7:0] rf_rdata_out, // Register read data
	output logic rf_rvalid_out, // Read data valid pulse
	// Control register side, to peripherals
	output logic ctrl_rd_out, // Control read pulse
	output logic ctrl_wr_out, // Control write pulse
	output logic [7:0] ctrl_addr_out, // Control register offset
	output logic [7:0] ctrl_wdata_out, // Control write data
	input wire logic [7:0] ctrl_rdata_in, // Control read data
	input wire logic ctrl_rsvd_in, // Offset is reserved
	// Program memory port
	input wire logic pm_rd_in, // Program fetch strobe
	input wire logic [15:0] pm_addr_in, // Program address
	output logic [7:0] pm_rdata_out, // Program read data
	output logic pm_rvalid_out, // Program data valid pulse
	output logic [2:0] pm_region_out, // Region of last fetch
	// Flash and info area storage
	output logic [15:0] flash_addr_out, // Flash byte address
	output logic flash_rd_out, // Flash read pulse
	input wire logic [7:0] flash_rdata_in, // Flash data, in the flash read pulse cycle
	input wire logic info_en_in, // Information area enable
	output logic [6:0] info_addr_out, // Info area offset
	output logic info_rd_out, // Info read pulse
	input wire logic [7:0] info_rdata_in, // Info data, in the info read pulse cycle
	// Vector fetch
	input wire logic vec_req_in, // Fetch vector pulse
	input wire logic [15:0] vec_addr_in, // Vector entry, even address
	output logic [15:0] vec_out, // Assembled vector
	output logic vec_valid_out, // Vector valid pulse
	// Data memory space
	input wire logic dm_rd_in, // Data memory read strobe
	output logic [7:0] dm_rdata_out, // Data memory read data
	output logic dm_rvalid_out // Data memory valid pulse
);
	localparam int RAM_AW = $clog2(`RAM_BYTES_MAX);

	typedef enum logic [1:0] {
		VEC_IDLE,
		VEC_HIGH,
		VEC_LOW,
		VEC_DONE
	} vec_state_t;

	// Register file region decode
	function automatic addr_map_pkg::rf_region_t rf_decode(input logic [11:0] a);
		if (a >= `RF_CTRL_BASE) begin
			rf_decode = addr_map_pkg::RF_CTRL;
		end else if (32'(a) < RAM_BYTES) begin
			rf_decode = addr_map_pkg::RF_RAM;
		end else begin
			rf_decode = addr_map_pkg::RF_HOLE;
		end
	endfunction

	// Program memory region decode, info overlay first
	function automatic addr_map_pkg::pm_region_t pm_decode(input logic [15:0] a,
			input logic info);
		if (info && a >= `PM_INFO_BASE && a <= `PM_INFO_LAST) begin
			pm_decode = addr_map_pkg::PM_INFO;
		end else if (a <= `PM_OPTION_LAST) begin
			pm_decode = addr_map_pkg::PM_OPTION;
		end else if (a >= `PM_RSVD_BASE && a <= `PM_RSVD_LAST) begin
			pm_decode = addr_map_pkg::PM_RESERVED;
		end else if (a < `PM_CODE_BASE) begin
			pm_decode = addr_map_pkg::PM_VECTOR;
		end else if (32'(a) < FLASH_BYTES) begin
			pm_decode = addr_map_pkg::PM_CODE;
		end else begin
			pm_decode = addr_map_pkg::PM_UNPOP;
		end
	endfunction

	addr_map_pkg::rf_region_t rf_reg;
	addr_map_pkg::pm_region_t pm_reg;
	logic ram_wr;
	logic [7:0] ram_rdata;

	// Live decode of incoming requests
	assign rf_reg = rf_decode(rf_addr_in);
	assign pm_reg = pm_decode(pm_addr_in, info_en_in);
	// Hole writes never reach storage
	assign ram_wr = rf_wr_in && rf_reg == addr_map_pkg::RF_RAM;

	byte_ram #(
		.DEPTH(`RAM_BYTES_MAX),
		.AW(RAM_AW)
	) i_byte_ram (
		.sys_clk_in(sys_clk_in),
		.addr_in(rf_addr_in[RAM_AW-1:0]),
		.wr_in(ram_wr),
		.wdata_in(rf_wdata_in),
		.rdata_out(ram_rdata)
	);

	// Register file pipeline state
	logic rf_pend_q, rf_pend_d;
	addr_map_pkg::rf_region_t rf_src_q, rf_src_d;
	logic ctrl_rd_q, ctrl_rd_d;
	logic ctrl_wr_q, ctrl_wr_d;
	logic [7:0] ctrl_addr_q, ctrl_addr_d;
	logic [7:0] ctrl_wdata_q, ctrl_wdata_d;
	logic [7:0] rf_rdata_q, rf_rdata_d;
	logic rf_rvalid_q, rf_rvalid_d;

	// Read answers two cycles after strobe, both paths aligned
	always_comb begin
		rf_pend_d = rf_rd_in;
		rf_src_d = rf_reg;
		ctrl_rd_d = rf_rd_in && rf_reg == addr_map_pkg::RF_CTRL;
		// Reserved offsets are still passed on; software must avoid writing them
		ctrl_wr_d = rf_wr_in && rf_reg == addr_map_pkg::RF_CTRL;
		ctrl_addr_d = rf_addr_in[7:0];
		ctrl_wdata_d = rf_wdata_in;
		rf_rvalid_d = rf_pend_q;
		rf_rdata_d = `UNDEF_BYTE;
		if (rf_pend_q) begin
			if (rf_src_q == addr_map_pkg::RF_RAM) begin
				rf_rdata_d = ram_rdata;
			end else if (rf_src_q == addr_map_pkg::RF_CTRL && !ctrl_rsvd_in) begin
				rf_rdata_d = ctrl_rdata_in;
			end
		end else begin
			rf_rdata_d = rf_rdata_q;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			rf_pend_q <= 1'b0;
			rf_src_q <= addr_map_pkg::RF_HOLE;
			ctrl_rd_q <= 1'b0;
			ctrl_wr_q <= 1'b0;
			ctrl_addr_q <= 8'h00;
			ctrl_wdata_q <= 8'h00;
			rf_rdata_q <= 8'h00;
			rf_rvalid_q <= 1'b0;
		end else begin
			rf_pend_q <= rf_pend_d;
			rf_src_q <= rf_src_d;
			ctrl_rd_q <= ctrl_rd_d;
			ctrl_wr_q <= ctrl_wr_d;
			ctrl_addr_q <= ctrl_addr_d;
			ctrl_wdata_q <= ctrl_wdata_d;
			rf_rdata_q <= rf_rdata_d;
			rf_rvalid_q <= rf_rvalid_d;
		end
	end

	// Program fetch and vector state
	vec_state_t vst_q, vst_d;
	logic [15:0] vaddr_q, vaddr_d;
	logic [15:0] vec_q, vec_d;
	logic vec_valid_q, vec_valid_d;
	logic fetch_q, fetch_d;
	logic fetch_vec_q, fetch_vec_d;
	addr_map_pkg::pm_region_t pm_src_q, pm_src_d;
	logic [15:0] fa_q, fa_d;
	logic frd_q, frd_d;
	logic [6:0] ia_q, ia_d;
	logic ird_q, ird_d;
	logic [7:0] pm_rdata_q, pm_rdata_d;
	logic pm_rvalid_q, pm_rvalid_d;
	logic [2:0] pm_region_q, pm_region_d;
	logic dm_rvalid_q, dm_rvalid_d;
	logic [7:0] dm_rdata_q, dm_rdata_d;
	logic issue;
	logic [15:0] issue_addr;
	addr_map_pkg::pm_region_t issue_reg;
	logic [7:0] fetched;

	// Core fetch has priority; vector bytes issue when the port is free
	always_comb begin
		vst_d = vst_q;
		vaddr_d = vaddr_q;
		vec_d = vec_q;
		vec_valid_d = 1'b0;
		issue = pm_rd_in;
		issue_addr = pm_addr_in;
		issue_reg = pm_reg;
		fetch_vec_d = 1'b0;
		fetched = (pm_src_q == addr_map_pkg::PM_INFO) ? info_rdata_in : flash_rdata_in;
		if (pm_src_q == addr_map_pkg::PM_RESERVED || pm_src_q == addr_map_pkg::PM_UNPOP) begin
			fetched = `UNDEF_BYTE;
		end
		case (vst_q)
			VEC_IDLE: begin
				if (vec_req_in) begin
					vaddr_d = {vec_addr_in[15:1], 1'b0};
					vst_d = VEC_HIGH;
				end
			end
			VEC_HIGH: begin
				if (!pm_rd_in) begin
					issue = 1'b1;
					issue_addr = vaddr_q;
					issue_reg = pm_decode(vaddr_q, info_en_in);
					fetch_vec_d = 1'b1;
					vst_d = VEC_LOW;
				end
			end
			VEC_LOW: begin
				if (fetch_vec_q) begin
					vec_d[15:8] = fetched;
				end
				if (!pm_rd_in && !fetch_vec_q) begin
					issue = 1'b1;
					issue_addr = vaddr_q | 16'h0001;
					issue_reg = pm_decode(vaddr_q | 16'h0001, info_en_in);
					fetch_vec_d = 1'b1;
					vst_d = VEC_DONE;
				end
			end
			default: begin
				if (fetch_vec_q) begin
					vec_d[7:0] = fetched;
					vec_valid_d = 1'b1;
					vst_d = VEC_IDLE;
				end
			end
		endcase
		fetch_d = issue && !fetch_vec_d;
		pm_src_d = issue_reg;
		fa_d = issue_addr;
		frd_d = issue && issue_reg != addr_map_pkg::PM_INFO;
		ia_d = issue_addr[6:0];
		ird_d = issue && issue_reg == addr_map_pkg::PM_INFO;
		pm_rvalid_d = fetch_q;
		pm_rdata_d = fetch_q ? fetched : pm_rdata_q;
		pm_region_d = fetch_q ? 3'(pm_src_q) : pm_region_q;
		dm_rvalid_d = dm_rd_in;
		dm_rdata_d = `UNDEF_BYTE;
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			vst_q <= VEC_IDLE;
			vaddr_q <= 16'h0000;
			vec_q <= 16'h0000;
			vec_valid_q <= 1'b0;
			fetch_q <= 1'b0;
			fetch_vec_q <= 1'b0;
			pm_src_q <= addr_map_pkg::PM_UNPOP;
			fa_q <= 16'h0000;
			frd_q <= 1'b0;
			ia_q <= 7'h00;
			ird_q <= 1'b0;
			pm_rdata_q <= 8'h00;
			pm_rvalid_q <= 1'b0;
			pm_region_q <= 3'h0;
			dm_rvalid_q <= 1'b0;
			dm_rdata_q <= 8'h00;
		end else begin
			vst_q <= vst_d;
			vaddr_q <= vaddr_d;
			vec_q <= vec_d;
			vec_valid_q <= vec_valid_d;
			fetch_q <= fetch_d;
			fetch_vec_q <= fetch_vec_d;
			pm_src_q <= pm_src_d;
			fa_q <= fa_d;
			frd_q <= frd_d;
			ia_q <= ia_d;
			ird_q <= ird_d;
			pm_rdata_q <= pm_rdata_d;
			pm_rvalid_q <= pm_rvalid_d;
			pm_region_q <= pm_region_d;
			dm_rvalid_q <= dm_rvalid_d;
			dm_rdata_q <= dm_rdata_d;
		end
	end

	// Outputs straight from flops
	assign rf_rdata_out = rf_rdata_q;
	assign rf_rvalid_out = rf_rvalid_q;
	assign ctrl_rd_out = ctrl_rd_q;
	assign ctrl_wr_out = ctrl_wr_q;
	assign ctrl_addr_out = ctrl_addr_q;
	assign ctrl_wdata_out = ctrl_wdata_q;
	assign flash_addr_out = fa_q;
	assign flash_rd_out = frd_q;
	assign info_addr_out = ia_q;
	assign info_rd_out = ird_q;
	assign pm_rdata_out = pm_rdata_q;
	assign pm_rvalid_out = pm_rvalid_q;
	assign pm_region_out = pm_region_q;
	assign vec_out = vec_q;
	assign vec_valid_out = vec_valid_q;
	// Nothing is mapped in data memory
	assign dm_rdata_out = dm_rdata_q;
	assign dm_rvalid_out = dm_rvalid_q;
endmodule

//--- rtl/byte_ram.sv
// Single-port byte memory with registered read data
`timescale 1ns/1ps
module byte_ram #(
	parameter int DEPTH = 1024,
	parameter int AW = 10
) (
	input wire logic sys_clk_in, // Core clock
	input wire logic [AW-1:0] addr_in, // Byte address
	input wire logic wr_in, // Write strobe
	input wire logic [7:0] wdata_in, // Write data
	output logic [7:0] rdata_out // Registered read data
);
	logic [7:0] mem_q [0:DEPTH-1];
	logic [7:0] rdata_q;

	// Write-first is not needed; read returns old contents
	always_ff @(posedge sys_clk_in) begin
		if (wr_in) begin
			mem_q[addr_in] <= wdata_in;
		end
		rdata_q <= mem_q[addr_in];
	end

	assign rdata_out = rdata_q;
endmodule

//--- tb/decoder_chk.sv
// Port-level checker for the address space decoder
`timescale 1ns/1ps
module decoder_chk #(
	parameter int RAM_BYTES = 1024
) (
	input wire logic sys_clk_in, // Core clock
	input wire logic reset_in, // Sync reset
	input wire logic rf_rd_in, // Register read
	input wire logic rf_wr_in, // Register write
	input wire logic [11:0] rf_addr_in, // Register address
	input wire logic [7:0] rf_rdata_out, // Register data
	input wire logic rf_rvalid_out, // Register valid
	input wire logic ctrl_rd_out, // Control read
	input wire logic ctrl_wr_out, // Control write
	input wire logic [7:0] ctrl_addr_out, // Control offset
	input wire logic pm_rd_in, // Fetch strobe
	input wire logic [15:0] pm_addr_in, // Fetch address
	input wire logic pm_rvalid_out, // Fetch valid
	input wire logic info_en_in, // Info enable
	input wire logic info_rd_out, // Info read
	input wire logic flash_rd_out, // Flash read
	input wire logic dm_rd_in, // Data space read
	input wire logic [7:0] dm_rdata_out, // Data space data
	input wire logic dm_rvalid_out // Data space valid
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	// Answers arrive two cycles after the request
	AST_RF_ANSWER: assert property (rf_rd_in |-> ##2 rf_rvalid_out)
		else $error("register read not answered");
	AST_PM_ANSWER: assert property (pm_rd_in |-> ##2 pm_rvalid_out)
		else $error("fetch not answered");
	// Top page goes out to the peripherals with its offset
	AST_CTRL_RD: assert property (rf_rd_in && rf_addr_in[11:8] == 4'hF |=>
		ctrl_rd_out && ctrl_addr_out == $past(rf_addr_in[7:0]))
		else $error("control read missing");
	AST_CTRL_WR: assert property (rf_wr_in && rf_addr_in[11:8] == 4'hF |=> ctrl_wr_out)
		else $error("control write missing");
	AST_NO_CTRL: assert property ((rf_rd_in || rf_wr_in) && rf_addr_in[11:8] != 4'hF
		|=> !ctrl_rd_out && !ctrl_wr_out)
		else $error("control strobe for general address");
	// Hole between RAM and control page reads as zero
	AST_HOLE: assert property (rf_rd_in && rf_addr_in >= RAM_BYTES && rf_addr_in[11:8] != 4'hF
		|-> ##2 rf_rdata_out == 8'h00)
		else $error("hole read not zero");
	AST_INFO: assert property (pm_rd_in && info_en_in && pm_addr_in inside {[16'hFE00:16'hFF7F]}
		|=> info_rd_out && !flash_rd_out)
		else $error("info overlay missing");
	AST_DM: assert property (dm_rd_in |=> dm_rvalid_out && dm_rdata_out == 8'h00)
		else $error("data space not empty");
endmodule
bind addr_space_decoder decoder_chk #(.RAM_BYTES(RAM_BYTES)) i_decoder_chk (.sys_clk_in,
	.reset_in, .rf_rd_in, .rf_wr_in, .rf_addr_in, .rf_rdata_out, .rf_rvalid_out, .ctrl_rd_out,
	.ctrl_wr_out, .ctrl_addr_out, .pm_rd_in, .pm_addr_in, .pm_rvalid_out, .info_en_in,
	.info_rd_out, .flash_rd_out, .dm_rd_in, .dm_rdata_out, .dm_rvalid_out);

//--- tb/mcu_address_space_decoder_test.sv
// Directed testbench for the address space decoder
`timescale 1ns/1ps
module mcu_address_space_decoder_test;
	logic sys_clk_in, reset_in, rf_rd, rf_wr, pm_rd, info_en, vec_req, dm_rd;
	logic [11:0] rf_addr;
	logic [7:0] rf_wdata, rf_rdata, ctrl_addr, ctrl_wdata, ctrl_rdata, fl_d, in_d, dm_d, pm_d;
	logic rf_v, ctrl_rd, ctrl_wr, ctrl_rsvd, pm_v, fl_rd, in_rd, vec_v, dm_v;
	logic [15:0] pm_addr, vec_addr, fl_addr, vec;
	logic [2:0] pm_reg;
	logic [6:0] in_addr;
	int fails = 0;
	int samples_checked = 0;
	addr_space_decoder #(.RAM_BYTES(256)) i_addr_space_decoder (.sys_clk_in, .reset_in,
		.rf_rd_in(rf_rd), .rf_wr_in(rf_wr), .rf_addr_in(rf_addr), .rf_wdata_in(rf_wdata),
		.rf_rdata_out(rf_rdata), .rf_rvalid_out(rf_v), .ctrl_rd_out(ctrl_rd),
		.ctrl_wr_out(ctrl_wr), .ctrl_addr_out(ctrl_addr), .ctrl_wdata_out(ctrl_wdata),
		.ctrl_rdata_in(ctrl_rdata), .ctrl_rsvd_in(ctrl_rsvd), .pm_rd_in(pm_rd),
		.pm_addr_in(pm_addr), .pm_rdata_out(pm_d), .pm_rvalid_out(pm_v), .pm_region_out(pm_reg),
		.flash_addr_out(fl_addr), .flash_rd_out(fl_rd), .flash_rdata_in(fl_d),
		.info_en_in(info_en), .info_addr_out(in_addr), .info_rd_out(in_rd),
		.info_rdata_in(in_d), .vec_req_in(vec_req), .vec_addr_in(vec_addr), .vec_out(vec),
		.vec_valid_out(vec_v), .dm_rd_in(dm_rd), .dm_rdata_out(dm_d), .dm_rvalid_out(dm_v));
	store_model i_store_model (.sys_clk_in, .flash_addr_in(fl_addr), .flash_rd_in(fl_rd),
		.info_addr_in(in_addr), .info_rd_in(in_rd), .ctrl_rd_in(ctrl_rd),
		.ctrl_addr_in(ctrl_addr), .flash_rdata_out(fl_d), .info_rdata_out(in_d),
		.ctrl_rdata_out(ctrl_rdata), .ctrl_rsvd_out(ctrl_rsvd));
	// Free-running 20 MHz clock
	initial begin
		sys_clk_in = 0;
		forever #25 sys_clk_in = ~sys_clk_in;
	end
	task automatic chk(input logic [15:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		if (fails == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	function automatic logic [7:0] fl(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction
	// One register access; writes to the top page are seen at the peripheral side
	task automatic rf(input logic wr, input logic [11:0] a, input logic [7:0] d, exp);
		@(posedge sys_clk_in) rf_rd <= !wr;
		rf_wr <= wr;
		rf_addr <= a;
		rf_wdata <= d;
		@(posedge sys_clk_in) rf_rd <= 0;
		rf_wr <= 0;
		#1 chk(ctrl_wr, wr && a[11:8] == 4'hF);
		if (wr && ctrl_wr) chk(ctrl_wdata, d);
		if (!wr) begin
			@(posedge sys_clk_in) #1 chk(rf_v, 1);
			chk(rf_rdata, exp);
		end
	endtask
	task automatic pm(input logic [15:0] a, input logic [2:0] r, input logic [7:0] exp);
		@(posedge sys_clk_in) pm_rd <= 1;
		pm_addr <= a;
		@(posedge sys_clk_in) pm_rd <= 0;
		@(posedge sys_clk_in) #1 chk(pm_v, 1);
		chk(pm_reg, r);
		chk(pm_d, exp);
	endtask
	// RAM from zero, hole writes lost even where they would alias
	task automatic t_rf;
		rf(1, 12'h000, 8'h3C, 0);
		rf(1, 12'h0FF, 8'hC3, 0);
		rf(1, 12'h400, 8'h99, 0);
		rf(1, 12'h100, 8'h77, 0);
		rf(0, 12'h000, 0, 8'h3C);
		rf(0, 12'h0FF, 0, 8'hC3);
		rf(0, 12'h100, 0, 8'h00);
		rf(0, 12'hEFF, 0, 8'h00);
		rf(1, 12'hF20, 8'h6B, 0);
		rf(0, 12'hF10, 0, 8'h4A);
		rf(0, 12'hFFF, 0, 8'h00);
	endtask
	// Low map regions, end of fitted flash, info overlay
	task automatic t_pm;
		pm(16'h0001, 3'h0, fl(16'h0001));
		pm(16'h0004, 3'h1, fl(16'h0004));
		pm(16'h0006, 3'h1, fl(16'h0006));
		pm(16'h0037, 3'h1, fl(16'h0037));
		pm(16'h0039, 3'h2, 8'h00);
		pm(16'h003D, 3'h1, fl(16'h003D));
		pm(16'h003E, 3'h3, fl(16'h003E));
		pm(16'h1FFF, 3'h3, fl(16'h1FFF));
		pm(16'h2000, 3'h5, 8'h00);
		pm(16'hFE00, 3'h5, 8'h00);
		@(posedge sys_clk_in) info_en <= 1;
		pm(16'hFE00, 3'h4, 8'hBC);
		pm(16'hFF7F, 3'h4, 8'hC3);
		pm(16'hFF80, 3'h5, 8'h00);
		@(posedge sys_clk_in) info_en <= 0;
	endtask
	// Mid-run reset clears held outputs but not RAM contents
	task automatic t_reset;
		rf(0, 12'h000, 0, 8'h3C);
		@(posedge sys_clk_in) reset_in <= 1;
		@(posedge sys_clk_in) reset_in <= 0;
		#1 chk(rf_rdata, 0);
		chk(pm_d, 0);
		chk(vec, 0);
		chk(rf_v, 0);
		rf(0, 12'h000, 0, 8'h3C);
	endtask
	// Reset vector assembled high byte first, then empty data space
	task automatic t_vec_dm;
		int i;
		@(posedge sys_clk_in) vec_req <= 1;
		vec_addr <= 16'h0002;
		@(posedge sys_clk_in) vec_req <= 0;
		for (i = 0; i < 20 && vec_v !== 1'b1; i++) @(posedge sys_clk_in) #1;
		chk(vec_v, 1);
		chk(vec, {fl(16'h0002), fl(16'h0003)});
		@(posedge sys_clk_in) dm_rd <= 1;
		@(posedge sys_clk_in) dm_rd <= 0;
		#1 chk(dm_v, 1);
		chk(dm_d, 8'h00);
	endtask
	// Main sequence
	initial begin
		{reset_in, rf_rd, rf_wr, pm_rd, info_en, vec_req, dm_rd} = 7'h40;
		{rf_addr, rf_wdata, pm_addr, vec_addr} = '0;
		repeat (20) @(posedge sys_clk_in);
		reset_in <= 0;
		t_rf;
		t_pm;
		t_vec_dm;
		t_reset;
		test_done;
	end
	// Hang guard
	initial begin
		repeat (2000) @(posedge sys_clk_in);
		fails++;
		test_done;
	end
endmodule

//--- tb/store_model.sv
// Flash, info area and peripheral register model behind the decoder
`timescale 1ns/1ps
module store_model (
	input wire logic sys_clk_in, // Core clock
	input wire logic [15:0] flash_addr_in, // Flash address
	input wire logic flash_rd_in, // Flash read
	input wire logic [6:0] info_addr_in, // Info offset
	input wire logic info_rd_in, // Info read
	input wire logic ctrl_rd_in, // Control read
	input wire logic [7:0] ctrl_addr_in, // Control offset
	output logic [7:0] flash_rdata_out, // Flash data
	output logic [7:0] info_rdata_out, // Info data
	output logic [7:0] ctrl_rdata_out, // Control data
	output logic ctrl_rsvd_out // Offset FF reserved
);
	logic [7:0] fl_byte;
	logic [7:0] in_byte;
	// Contents derived from the address so every byte within one 256-byte page is distinct
	assign fl_byte = flash_addr_in[7:0] ^ flash_addr_in[15:8] ^ 8'hA5;
	assign in_byte = {1'b1, info_addr_in} ^ 8'h3C;
	// Data stands in the strobe cycle; an idle port shows the inverse
	assign flash_rdata_out = flash_rd_in ? fl_byte : ~fl_byte;
	assign info_rdata_out = info_rd_in ? in_byte : ~in_byte;
	// Peripheral answer in the strobe cycle
	assign ctrl_rdata_out = ctrl_rd_in ? ctrl_addr_in ^ 8'h5A : ctrl_addr_in ^ 8'hA5;
	assign ctrl_rsvd_out = ctrl_addr_in == 8'hFF;
endmodule
